// ### hdl/sadst_pkg.sv
// Constants, field layouts and helpers for the slot-assignment and drop-statistics registers
package sadst_pkg;

  localparam logic [7:0]  SLOT_SELECTOR_OFFSET    = 8'h70;
  localparam logic [7:0]  SLOT_ASSIGN_DATA_OFFSET = 8'h74;
  localparam logic [7:0]  ESCAPE_MAP_OFFSET       = 8'h80;
  localparam logic [7:0]  BUF_FAIL_COUNT_OFFSET   = 8'h84;
  localparam logic [7:0]  DROP_SELECTOR_OFFSET    = 8'h88;
  localparam logic [7:0]  DROP_DATA_OFFSET        = 8'h8c;
  localparam logic [7:0]  IRQ_STATUS_OFFSET       = 8'hc0;
  localparam logic [7:0]  IRQ_MASK_OFFSET         = 8'hc4;

  localparam logic [31:0] SLOT_ASSIGN_RESET       = 32'h02000000;
  localparam int          SEL_DIR_BIT             = 31;
  localparam int          SEL_SLOT_STEP_BIT       = 23;
  localparam int          DROP_CHANNEL_SELECT_STEP_BIT      = 23;
  localparam int          DROP_CLEAR_BIT          = 22;
  localparam int          ENTRY_INHIBIT_BIT       = 25;
  localparam int          ENTRY_FIRST_BIT         = 24;
  localparam int          IRQ_BUF_FAIL_BIT        = 0;
  localparam int          IRQ_DROP_BIT            = 1;
  localparam logic [7:0]  DROP_CHANNEL_SELECT_STEP          = 8'h02;
  localparam logic [1:0]  RESP_OKAY               = 2'h0;
  localparam logic [1:0]  RESP_SLVERR             = 2'h2;

  // Table entry: inhibit, superchannel first, channel, mask
  typedef struct packed {
    logic       inhibit;
    logic       superchannel_first;
    logic [7:0] channel_select;
    logic [7:0] mask;
  } sadst_entry_type;

  function automatic logic [31:0] strb_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old_val[b*8 +: 8] = strb[b] ? new_val[b*8 +: 8] : old_val[b*8 +: 8];
    end
    return old_val;
  endfunction

  function automatic logic [31:0] entry_to_word(input sadst_entry_type e);
    return {6'h00, e.inhibit, e.superchannel_first, 8'h00, e.channel_select, e.mask};
  endfunction

  // Register word to table entry, reserved bits dropped
  function automatic sadst_entry_type word_to_entry(input logic [31:0] w);
    return {w[ENTRY_INHIBIT_BIT], w[ENTRY_FIRST_BIT], w[15:0]};
  endfunction

endpackage

// ### hdl/sadst_tbl_if.sv
// Access carrier between the register logic and the slot assignment table
`timescale 1ns/1ps
interface sadst_tbl_if #(parameter int IDX_W = 13);
  logic                     wr_en;
  logic [IDX_W-1:0]         host_index;
  sadst_pkg::sadst_entry_type wr_entry;
  sadst_pkg::sadst_entry_type host_entry;
  logic [IDX_W-1:0]         line_index;
  sadst_pkg::sadst_entry_type line_entry;

  modport host  (output wr_en, output host_index, output wr_entry, input host_entry,
                 output line_index, input line_entry);
  modport store (input wr_en, input host_index, input wr_entry, output host_entry,
                 input line_index, output line_entry);
endinterface

// ### hdl/sadst_slot_table.sv
// Slot assignment storage, one entry per direction, port and slot
`timescale 1ns/1ps
module sadst_slot_table #(
  parameter int IDX_W = 13
) (
  input wire logic  aclk,     // System clock
  input wire logic  aresetn,  // Synchronous reset, active low
  input wire logic  ce,       // Clock enable
  sadst_tbl_if.store tbl      // Host and line access
);

  sadst_pkg::sadst_entry_type entries [2**IDX_W];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2**IDX_W; i++) begin
        entries[i] <= sadst_pkg::word_to_entry(sadst_pkg::SLOT_ASSIGN_RESET);
      end
    end else if (ce && tbl.wr_en) begin
      entries[tbl.host_index] <= tbl.wr_entry;
    end
  end

  assign tbl.host_entry = entries[tbl.host_index];
  assign tbl.line_entry = entries[tbl.line_index];

endmodule

// ### hdl/sadst_drop_counters.sv
// Per-channel small-frame drop counters, read in pairs
`timescale 1ns/1ps
module sadst_drop_counters #(
  parameter int CH_W  = 8,
  parameter int CNT_W = 16
) (
  input  wire logic               aclk,       // System clock
  input  wire logic               aresetn,    // Synchronous reset, active low
  input  wire logic               ce,         // Clock enable
  input  wire logic               drop_valid, // One small frame dropped
  input  wire logic [CH_W-1:0]    drop_channel_select,  // Channel of the dropped frame
  input  wire logic [CH_W-1:0]    sel_channel_select,   // Selected channel N
  input  wire logic               clear,      // Zero counts of N and N+1
  output logic      [2*CNT_W-1:0] pair        // {count N+1, count N}
);

  logic [CNT_W-1:0] counts [2**CH_W];
  logic [CH_W-1:0]  next_channel_select;

  assign next_channel_select = sel_channel_select + CH_W'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2**CH_W; i++) begin
        counts[i] <= '0;
      end
    end else if (ce) begin
      for (int i = 0; i < 2**CH_W; i++) begin
        // clear after read, new drop wins
        if (clear && (CH_W'(i) == sel_channel_select || CH_W'(i) == next_channel_select)) begin
          counts[i] <= (drop_valid && drop_channel_select == CH_W'(i)) ? CNT_W'(1) : '0;
        end else if (drop_valid && drop_channel_select == CH_W'(i)) begin
          counts[i] <= counts[i] + CNT_W'(1);
        end
      end
    end
  end

  assign pair = {counts[next_channel_select], counts[sel_channel_select]};

endmodule

// ### hdl/sadst_regs.sv
// Slot assignment and drop statistics register bank with AXI4-Lite slave
`timescale 1ns/1ps
module sadst_regs #(
  parameter int PORT_W = 5,
  parameter int SLOT_W = 7
) (
  input  wire logic              aclk,             // System clock, 40 MHz
  input  wire logic              aresetn,          // Synchronous reset, active low
  input  wire logic              ce,               // Clock enable, freezes all state
  input  wire logic [7:0]        s_axi_awaddr,     // Write address
  input  wire logic              s_axi_awvalid,    // Write address valid
  output logic                   s_axi_awready,    // Write address ready
  input  wire logic [31:0]       s_axi_wdata,      // Write data
  input  wire logic [3:0]        s_axi_wstrb,      // Write byte strobes
  input  wire logic              s_axi_wvalid,     // Write data valid
  output logic                   s_axi_wready,     // Write data ready
  output logic [1:0]             s_axi_bresp,      // Write response
  output logic                   s_axi_bvalid,     // Write response valid
  input  wire logic              s_axi_bready,     // Write response ready
  input  wire logic [7:0]        s_axi_araddr,     // Read address
  input  wire logic              s_axi_arvalid,    // Read address valid
  output logic                   s_axi_arready,    // Read address ready
  output logic [31:0]            s_axi_rdata,      // Read data
  output logic [1:0]             s_axi_rresp,      // Read response
  output logic                   s_axi_rvalid,     // Read data valid
  input  wire logic              s_axi_rready,     // Read data ready
  input  wire logic              line_valid,       // Slot lookup request
  input  wire logic              line_dir,         // 0 receive, 1 transmit
  input  wire logic [PORT_W-1:0] line_port,        // Port of the slot
  input  wire logic [SLOT_W-1:0] line_slot,        // Slot number
  input  wire logic [7:0]        line_rx_octet,    // Octet received on the slot
  input  wire logic [7:0]        line_tx_octet,    // Octet from the protocol engine
  output logic                   line_out_valid,   // Lookup result valid
  output logic [7:0]             line_channel,     // Channel bound to the slot
  output logic [7:0]             line_rx_keep,     // Received bits passed on
  output logic [7:0]             line_rx_data,     // Received octet, dropped bits zero
  output logic [7:0]             line_tx_data,     // Transmit octet
  output logic [7:0]             line_tx_oe_n,     // Transmit bit enable, low drives
  output logic                   line_first,       // Superchannel starts on this slot
  input  wire logic              esc_valid,        // Received character to check
  input  wire logic [7:0]        esc_char,         // Received character
  input  wire logic [3:0]        escape_enable_flags, // Per-channel map enables
  output logic                   esc_hit,          // Character is escape mapped
  input  wire logic              buf_fail,         // Packet lost, buffer unreachable
  input  wire logic              drop_valid,       // Small frame dropped
  input  wire logic [7:0]        drop_channel_select,        // Channel of the small frame
  output logic                   irq               // Interrupt, active high level
);

  localparam int IDX_W = 1 + PORT_W + SLOT_W;

  sadst_tbl_if #(.IDX_W(IDX_W)) tbl ();

  logic              aw_held;
  logic              w_held;
  logic [7:0]        waddr;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wr_fire;
  logic              rd_fire;
  logic [31:0]       rd_val;
  logic              rd_err;
  logic              wr_err;

  logic              sel_dir;
  logic              sel_slot_step;
  logic [PORT_W-1:0] sel_port;
  logic [SLOT_W-1:0] slot_number;
  logic [31:0]       receive_escape_char_map;
  logic [31:0]       buffer_access_fail_count;
  logic              channel_auto_step;
  logic              clear_on_read;
  logic [7:0]        channel_select;
  logic [31:0]       drop_pair;
  logic [1:0]        irq_status;
  logic [1:0]        irq_mask;
  logic [1:0]        irq_events;
  logic [31:0]       slot_word;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign irq_events = {drop_valid, buf_fail};

  //////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  sadst_slot_table #(.IDX_W(IDX_W)) u_table (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tbl     (tbl.store)
  );

  sadst_drop_counters #(.CH_W(8), .CNT_W(16)) u_drop (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .drop_valid (drop_valid),
    .drop_channel_select  (drop_channel_select),
    .sel_channel_select   (channel_select),
    .clear      (rd_fire && s_axi_araddr == sadst_pkg::DROP_DATA_OFFSET && clear_on_read),
    .pair       (drop_pair)
  );

  assign tbl.host_index = {sel_dir, sel_port, slot_number};
  assign tbl.line_index = {line_dir, line_port, line_slot};
  assign slot_word      = sadst_pkg::entry_to_word(tbl.host_entry);
  // write binds channel and mask to selection
  assign tbl.wr_en      = ce && wr_fire && waddr == sadst_pkg::SLOT_ASSIGN_DATA_OFFSET;
  assign tbl.wr_entry   = sadst_pkg::word_to_entry(sadst_pkg::strb_merge(slot_word, wdata, wstrb));

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      waddr         <= 8'h00;
      wdata         <= 32'h00000000;
      wstrb         <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sadst_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        waddr         <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        wdata        <= s_axi_wdata;
        wstrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? sadst_pkg::RESP_SLVERR : sadst_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= sadst_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_err ? sadst_pkg::RESP_SLVERR : sadst_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  always_comb begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    if (s_axi_araddr == sadst_pkg::SLOT_SELECTOR_OFFSET) begin
      rd_val = {sel_dir, 7'h00, sel_slot_step, 10'h000, sel_port, 1'b0, slot_number};
    end else if (s_axi_araddr == sadst_pkg::SLOT_ASSIGN_DATA_OFFSET) begin
      rd_val = slot_word;
    end else if (s_axi_araddr == sadst_pkg::ESCAPE_MAP_OFFSET) begin
      rd_val = receive_escape_char_map;
    end else if (s_axi_araddr == sadst_pkg::BUF_FAIL_COUNT_OFFSET) begin
      rd_val = buffer_access_fail_count;
    end else if (s_axi_araddr == sadst_pkg::DROP_SELECTOR_OFFSET) begin
      rd_val = {8'h00, channel_auto_step, clear_on_read, 14'h0000, channel_select};
    end else if (s_axi_araddr == sadst_pkg::DROP_DATA_OFFSET) begin
      rd_val = drop_pair;
    end else if (s_axi_araddr == sadst_pkg::IRQ_STATUS_OFFSET) begin
      rd_val = {30'h00000000, irq_status};
    end else if (s_axi_araddr == sadst_pkg::IRQ_MASK_OFFSET) begin
      rd_val = {30'h00000000, irq_mask};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_comb begin
    wr_err = 1'b1;
    if (waddr == sadst_pkg::SLOT_SELECTOR_OFFSET || waddr == sadst_pkg::SLOT_ASSIGN_DATA_OFFSET) begin
      wr_err = 1'b0;
    end else if (waddr == sadst_pkg::ESCAPE_MAP_OFFSET || waddr == sadst_pkg::BUF_FAIL_COUNT_OFFSET) begin
      wr_err = 1'b0;
    end else if (waddr == sadst_pkg::DROP_SELECTOR_OFFSET || waddr == sadst_pkg::DROP_DATA_OFFSET) begin
      wr_err = 1'b0;
    end else if (waddr == sadst_pkg::IRQ_STATUS_OFFSET || waddr == sadst_pkg::IRQ_MASK_OFFSET) begin
      wr_err = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Slot selector

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_dir       <= 1'b0;
      sel_slot_step <= 1'b0;
      sel_port      <= '0;
      slot_number   <= '0;
    end else if (ce) begin
      if (wr_fire && waddr == sadst_pkg::SLOT_SELECTOR_OFFSET) begin
        sel_dir       <= wstrb[3] ? wdata[sadst_pkg::SEL_DIR_BIT] : sel_dir;
        sel_slot_step <= wstrb[2] ? wdata[sadst_pkg::SEL_SLOT_STEP_BIT] : sel_slot_step;
        sel_port      <= wstrb[1] ? wdata[8 +: PORT_W] : sel_port;
        slot_number   <= wstrb[0] ? wdata[0 +: SLOT_W] : slot_number;
      end else if (sel_slot_step && ((wr_fire && waddr == sadst_pkg::SLOT_ASSIGN_DATA_OFFSET) ||
                                     (rd_fire && s_axi_araddr == sadst_pkg::SLOT_ASSIGN_DATA_OFFSET))) begin
        slot_number <= slot_number + SLOT_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Escape map and buffer failure count

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      receive_escape_char_map <= 32'h00000000;
      esc_hit                 <= 1'b0;
    end else if (ce) begin
      if (wr_fire && waddr == sadst_pkg::ESCAPE_MAP_OFFSET) begin
        receive_escape_char_map <= sadst_pkg::strb_merge(receive_escape_char_map, wdata, wstrb);
      end
      esc_hit <= 1'b0;
      for (int c = 0; c < 4; c++) begin
        if (esc_valid && escape_enable_flags[c] && esc_char == receive_escape_char_map[c*8 +: 8]) begin
          esc_hit <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_access_fail_count <= 32'h00000000;
    end else if (ce) begin
      if (rd_fire && s_axi_araddr == sadst_pkg::BUF_FAIL_COUNT_OFFSET) begin
        buffer_access_fail_count <= {31'h00000000, buf_fail};
      end else if (buf_fail) begin
        buffer_access_fail_count <= buffer_access_fail_count + 32'h00000001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Drop counter selector

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_auto_step <= 1'b0;
      clear_on_read     <= 1'b0;
      channel_select    <= 8'h00;
    end else if (ce) begin
      if (wr_fire && waddr == sadst_pkg::DROP_SELECTOR_OFFSET) begin
        channel_auto_step <= wstrb[2] ? wdata[sadst_pkg::DROP_CHANNEL_SELECT_STEP_BIT] : channel_auto_step;
        clear_on_read     <= wstrb[2] ? wdata[sadst_pkg::DROP_CLEAR_BIT] : clear_on_read;
        channel_select    <= wstrb[0] ? wdata[7:0] : channel_select;
      end else if (channel_auto_step && ((wr_fire && waddr == sadst_pkg::DROP_DATA_OFFSET) ||
                                         (rd_fire && s_axi_araddr == sadst_pkg::DROP_DATA_OFFSET))) begin
        channel_select <= channel_select + sadst_pkg::DROP_CHANNEL_SELECT_STEP;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
      irq        <= 1'b0;
    end else if (ce) begin
      if (rd_fire && s_axi_araddr == sadst_pkg::IRQ_STATUS_OFFSET) begin
        irq_status <= irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      if (wr_fire && waddr == sadst_pkg::IRQ_MASK_OFFSET && wstrb[0]) begin
        irq_mask <= wdata[1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line side slot processing

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_out_valid <= 1'b0;
      line_channel   <= 8'h00;
      line_rx_keep   <= 8'h00;
      line_rx_data   <= 8'h00;
      line_tx_data   <= 8'h00;
      line_tx_oe_n   <= 8'hff;
      line_first     <= 1'b0;
    end else if (ce) begin
      line_out_valid <= line_valid;
      line_channel   <= tbl.line_entry.channel_select;
      if (!line_valid || tbl.line_entry.inhibit) begin
        line_rx_keep <= 8'h00;
        line_rx_data <= 8'h00;
        line_tx_data <= 8'h00;
        line_tx_oe_n <= 8'hff;
        line_first   <= 1'b0;
      end else begin
        // zero mask bits drop and float
        // one mask bits pass and drive
        line_rx_keep <= line_dir ? 8'h00 : tbl.line_entry.mask;
        line_rx_data <= line_dir ? 8'h00 : (line_rx_octet & tbl.line_entry.mask);
        line_tx_data <= line_dir ? (line_tx_octet & tbl.line_entry.mask) : 8'h00;
        line_tx_oe_n <= line_dir ? ~tbl.line_entry.mask : 8'hff;
        line_first   <= tbl.line_entry.superchannel_first;
      end
    end
  end

endmodule

// ### tb/sadst_regs_properties.sv
// Port assertions for the register bank
`timescale 1ns/1ps
module sadst_regs_properties (
  input wire logic       aclk, aresetn, line_valid, line_out_valid,                // Clock, reset, lookup
  input wire logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, // Write request
  input wire logic       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, // Answer, read request
  input wire logic       s_axi_rvalid,                                             // Read answer
  input wire logic [7:0] line_rx_keep, line_rx_data, line_tx_oe_n                  // Slot results
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_look; line_out_valid == $past(line_valid); endproperty
  a_look: assert property (p_look) else $error("lookup result timing");
  property p_drop; (line_rx_data & ~line_rx_keep) == 8'h00; endproperty
  a_drop: assert property (p_drop) else $error("dropped bit passed");
  property p_rxoff; line_rx_keep != 8'h00 |-> line_tx_oe_n == 8'hff; endproperty
  a_rxoff: assert property (p_rxoff) else $error("receive lookup drives line");
  property p_idle; !line_out_valid |-> line_tx_oe_n == 8'hff && line_rx_keep == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle slot output active");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid);
  c_tx: cover property (line_tx_oe_n != 8'hff);
endmodule
bind sadst_regs sadst_regs_properties i_sadst_regs_properties (.*);

// ### tb/tb_sadst_regs.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb_sadst_regs;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, line_valid, line_dir, line_out_valid, line_first;
  logic esc_valid, esc_hit, buf_fail, drop_valid, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, line_rx_octet, line_tx_octet, line_channel, line_rx_keep, line_rx_data;
  logic [7:0] line_tx_data, line_tx_oe_n, esc_char, drop_channel_select, o;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, r, w, m, k;
  logic [3:0] s_axi_wstrb, escape_enable_flags;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [4:0] line_port;
  logic [6:0] line_slot;
  int failures, cmp_count, cyc;
  sadst_regs i_sadst_regs (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Bits of an entry that reach the line
  function automatic logic [7:0] kept(input logic [31:0] e);
    return e[25] ? 8'h00 : e[7:0];
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rs = s_axi_rresp;
    chk("rdata", e, s_axi_rdata);
  endtask
  task automatic step(input logic lv, input logic dir, input logic ev, input logic bf, input logic dv);
    {line_valid, line_dir, esc_valid, buf_fail, drop_valid} <= {lv, dir, ev, bf, dv};
    @(posedge aclk);
    {line_valid, esc_valid, buf_fail, drop_valid} <= 4'h0;
    @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    seed = 32'h9402;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, line_valid, line_dir} = 8'h00;
    {esc_valid, buf_fail, drop_valid, s_axi_awaddr, s_axi_araddr, s_axi_wdata, esc_char, drop_channel_select} = '0;
    {line_rx_octet, line_tx_octet, line_port, line_slot, escape_enable_flags} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(8'h74, 32'h02000000);
    rc(8'h80, 32'h0);
    rc(8'h84, 32'h0);
    rc(8'h10, 32'h0);
    chk("rresp", 32'h2, {30'h0, rs});
    wr(8'h14, 32'h1, sadst_pkg::RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      w = xs();
      o = w[23:16];
      m = xs() & 32'h0100ffff;
      k = xs() & 32'h0300ffff;
      {line_port, line_slot} <= {w[12:8], w[6:0]};
      {line_rx_octet, line_tx_octet} <= {o, o};
      wr(8'h70, {9'h101, 10'h0, w[12:8], 1'b0, w[6:0]}, 2'h0);
      wr(8'h74, m, 2'h0);
      wr(8'h74, ~m & 32'h0100ffff, 2'h0);
      wr(8'h70, {19'h0, w[12:8], 1'b0, w[6:0]}, 2'h0);
      wr(8'h74, k, 2'h0);
      rc(8'h74, k);
      wr(8'h70, {19'h40000, w[12:8], 1'b0, w[6:0] + 7'h1}, 2'h0);
      rc(8'h74, ~m & 32'h0100ffff);
      step(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      chk("tx_oe_n", {24'h0, ~m[7:0]}, line_tx_oe_n);
      chk("tx_data", o & m[7:0], line_tx_data);
      chk("first", m[24], line_first);
      chk("channel", m[15:8], line_channel);
      step(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      chk("rx_keep", kept(k), line_rx_keep);
      chk("rx_data", o & kept(k), line_rx_data);
    end
    // Single-slot superchannel, then retired
    {line_port, line_slot} <= 12'h000;
    wr(8'h70, 32'h80000000, 2'h0);
    wr(8'h74, 32'h010005ff, 2'h0);
    step(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("first", 32'h1, line_first);
    chk("tx_oe_n", 32'h0, line_tx_oe_n);
    wr(8'h74, 32'h02000000, 2'h0);
    step(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    chk("tx_oe_n", 32'hff, line_tx_oe_n);
    w = xs();
    wr(8'h80, w, 2'h0);
    for (int c = 0; c < 5; c++) begin
      esc_char <= w[8*(c%4) +: 8];
      escape_enable_flags <= (c < 4) ? 4'(1 << c) : 4'h0;
      step(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      chk("esc_hit", (c < 4), esc_hit);
    end
    wr(8'hc4, 32'h3, 2'h0);
    repeat (3) step(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    chk("irq", 32'h1, irq);
    rc(8'h84, 32'h3);
    rc(8'h84, 32'h0);
    rc(8'hc0, 32'h1);
    wr(8'hc4, 32'h0, 2'h0);
    drop_channel_select <= 8'hfe;
    repeat (2) step(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    drop_channel_select <= 8'hff;
    step(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk("irq", 32'h0, irq);
    wr(8'h88, 32'hfe, 2'h0);
    rc(8'h8c, 32'h00010002);
    rc(8'h8c, 32'h00010002);
    wr(8'h88, 32'h00c000fe, 2'h0);
    rc(8'h8c, 32'h00010002);
    rc(8'h8c, 32'h0);
    rc(8'h88, 32'h00c00002);
    wr(8'h88, 32'hfe, 2'h0);
    rc(8'h8c, 32'h0);
    stop_test();
  end
endmodule
